/* File: core/bus_area_pkg.sv */
package bus_area_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_AREAS = 8;
  // register offsets, lower 16 bits of the address
  localparam logic [15:0] CHIP_SELECT_CTRL_OFS = 16'hFF5F;
  localparam logic [15:0] AREA_WIDTH_CTRL_OFS = 16'hFFEC;
  localparam logic [15:0] AREA_STATE_COUNT_CTRL_OFS = 16'hFFED;
  localparam logic [15:0] WAIT_MODE_CTRL_OFS = 16'hFFEE;
  localparam logic [15:0] WAIT_INSERTION_ENABLE_OFS = 16'hFFEF;
  localparam logic [15:0] BUS_RELEASE_CTRL_OFS = 16'hFFF3;
  localparam logic [15:0] MASTER_STATUS_OFS = 16'hFFF4;
  // reset values
  localparam logic [7:0] CHIP_SELECT_CTRL_RST = 8'h0F;
  localparam logic [7:0] AREA_WIDTH_WIDE_RST = 8'h00;
  localparam logic [7:0] AREA_WIDTH_NARROW_RST = 8'hFF;
  localparam logic [7:0] AREA_STATE_COUNT_CTRL_RST = 8'hFF;
  localparam logic [7:0] WAIT_MODE_CTRL_RST = 8'hF3;
  localparam logic [7:0] WAIT_INSERTION_ENABLE_RST = 8'hFF;
  localparam logic [7:0] BUS_RELEASE_CTRL_RST = 8'hFE;
  // field positions
  localparam int WAIT_COUNT_LSB = 0;
  localparam int WAIT_MODE_LSB = 2;
  localparam logic [7:0] WAIT_MODE_CTRL_RO_ONES = 8'hF0;
  localparam int RELEASE_ENABLE_BIT = 0;
  // area index field of the address in each addressing mode
  localparam int AREA_LSB_SMALL = 17;
  localparam int AREA_LSB_LARGE = 21;
  typedef enum logic [1:0] {
    WAIT_PROGRAMMABLE = 2'h0,
    WAIT_NONE = 2'h1,
    WAIT_PIN_1 = 2'h2,
    WAIT_PIN_AUTO = 2'h3
  } wait_mode_t;
  typedef enum logic [1:0] {
    OWN_CPU = 2'h0,
    OWN_DMA = 2'h1,
    OWN_REFRESH = 2'h2,
    OWN_EXTERNAL = 2'h3
  } owner_t;
endpackage : bus_area_pkg

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic pin_i,
  input wire logic rst_val_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;
  sync_t q, d;
  always_comb begin
    d = q;
    d.s1 = pin_i ^ rst_val_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= 4'h0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end
  assign level_o = q.lvl ^ rst_val_i;
endmodule : pin_sync
`default_nettype wire

/* File: core/bus_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter
  import bus_area_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic cycle_idle_i,
  input wire logic release_en_i,
  input wire logic ext_req_i,
  input wire logic refresh_req_i,
  input wire logic dma_req_i,
  output bus_area_pkg::owner_t owner_o
);
  typedef struct packed {
    owner_t owner;
  } arb_t;
  arb_t q, d;
  always_comb begin
    d = q;
    if (cycle_idle_i) begin
      if (ext_req_i && release_en_i) begin
        d.owner = OWN_EXTERNAL;
      end else if (refresh_req_i) begin
        d.owner = OWN_REFRESH;
      end else if (dma_req_i) begin
        d.owner = OWN_DMA;
      end else begin
        d.owner = OWN_CPU;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q.owner <= OWN_CPU;
    end else if (clk_en_i) begin
      q <= d;
    end
  end
  assign owner_o = q.owner;
endmodule : bus_arbiter
`default_nettype wire

/* File: core/external_bus_area_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_area_controller
  import bus_area_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [2:0] op_mode_i,
  input wire logic large_space_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_wide_i,
  input wire logic [bus_area_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [bus_area_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic dma_req_i,
  input wire logic refresh_req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [bus_area_pkg::DATA_W-1:0] rsp_rdata_o,
  output bus_area_pkg::owner_t owner_o,
  output logic [bus_area_pkg::ADDR_W-1:0] addr_o,
  output logic addr_oe_n_o,
  output logic [bus_area_pkg::DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  input wire logic [bus_area_pkg::DATA_W-1:0] data_i,
  output logic [bus_area_pkg::NUM_AREAS-1:0] chip_sel_n_o,
  output logic addr_valid_strobe_n_o,
  output logic read_strobe_n_o,
  output logic upper_write_strobe_n_o,
  output logic lower_write_strobe_n_o,
  output logic strobe_oe_n_o,
  input wire logic wait_req_n_i,
  input wire logic bus_release_request_n_i,
  output logic bus_release_ack_n_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TW,
    ST_T3,
    ST_DONE
  } bus_state_t;
  typedef struct packed {
    logic [7:0] cs_ctrl;
    logic [7:0] width_ctrl;
    logic [7:0] state_ctrl;
    logic [7:0] wait_ctrl;
    logic [7:0] wait_en;
    logic [7:0] release_ctrl;
    logic [7:0] rdata;
    bus_state_t st;
    logic [2:0] area;
    logic write;
    logic second;
    logic split;
    logic [1:0] wcnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rbuf;
    logic rsp;
    logic [NUM_AREAS-1:0] cs_n;
    logic as_n;
    logic rd_n;
    logic hwr_n;
    logic lwr_n;
    logic boot;
  } ctl_t;
  ctl_t q, d;
  logic wait_lvl;
  logic bus_release_request_lvl;
  owner_t owner;
  logic [2:0] req_area;
  logic narrow;
  logic three;
  logic ctl_en;
  logic wide_reset;
  wait_mode_t wmode;
  logic [NUM_AREAS-1:0] area_hit;
  pin_sync wait_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .pin_i(wait_req_n_i),
    .rst_val_i(1'h1),
    .level_o(wait_lvl)
  );
  pin_sync bus_release_request_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .pin_i(bus_release_request_n_i),
    .rst_val_i(1'h1),
    .level_o(bus_release_request_lvl)
  );
  bus_arbiter arb (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .cycle_idle_i(q.st == ST_IDLE && !req_valid_i),
    .release_en_i(q.release_ctrl[RELEASE_ENABLE_BIT]),
    .ext_req_i(!bus_release_request_lvl),
    .refresh_req_i(refresh_req_i),
    .dma_req_i(dma_req_i),
    .owner_o(owner)
  );
  assign req_area = large_space_i ? req_addr_i[AREA_LSB_LARGE +: 3]
                                  : req_addr_i[AREA_LSB_SMALL +: 3];
  // one select line per area
  for (genvar g = 0; g < NUM_AREAS; g++) begin : g_area
    assign area_hit[g] = (req_area == 3'(g));
  end
  assign narrow = q.width_ctrl[q.area];
  assign three = q.state_ctrl[q.area];
  assign ctl_en = q.wait_en[q.area];
  assign wmode = wait_mode_t'(q.wait_ctrl[WAIT_MODE_LSB +: 2]);
  assign wide_reset = (op_mode_i == 3'h2) || (op_mode_i == 3'h4) || (op_mode_i == 3'h7);
  always_comb begin
    d = q;
    d.rsp = 1'h0;
    d.boot = 1'h0;
    d.rdata = 8'h00;
    if (q.boot) begin
      d.width_ctrl = wide_reset ? AREA_WIDTH_WIDE_RST : AREA_WIDTH_NARROW_RST;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        CHIP_SELECT_CTRL_OFS: d.cs_ctrl = reg_wdata_i;
        AREA_WIDTH_CTRL_OFS: d.width_ctrl = reg_wdata_i;
        AREA_STATE_COUNT_CTRL_OFS: d.state_ctrl = reg_wdata_i;
        WAIT_MODE_CTRL_OFS: d.wait_ctrl = reg_wdata_i | WAIT_MODE_CTRL_RO_ONES;
        WAIT_INSERTION_ENABLE_OFS: d.wait_en = reg_wdata_i;
        BUS_RELEASE_CTRL_OFS: d.release_ctrl = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        CHIP_SELECT_CTRL_OFS: d.rdata = q.cs_ctrl;
        AREA_WIDTH_CTRL_OFS: d.rdata = q.width_ctrl;
        AREA_STATE_COUNT_CTRL_OFS: d.rdata = q.state_ctrl;
        WAIT_MODE_CTRL_OFS: d.rdata = q.wait_ctrl;
        WAIT_INSERTION_ENABLE_OFS: d.rdata = q.wait_en;
        BUS_RELEASE_CTRL_OFS: d.rdata = q.release_ctrl;
        MASTER_STATUS_OFS: d.rdata = {3'h0, q.st != ST_IDLE, q.area, 1'h0} | {6'h0, owner};
        default: d.rdata = 8'h00;
      endcase
    end
    unique case (q.st)
      ST_IDLE: begin
        if (req_valid_i && owner != OWN_EXTERNAL) begin
          d.st = ST_T1;
          d.area = req_area;
          d.write = req_write_i;
          d.addr = req_addr_i;
          d.wdata = req_wdata_i;
          d.second = 1'h0;
          d.split = 1'h0;
          d.cs_n = ~area_hit;
          d.as_n = 1'h0;
          d.split = req_wide_i && q.width_ctrl[req_area];
        end
      end
      ST_T1: begin
        d.st = ST_T2;
        if (!q.write) begin
          d.rd_n = 1'h0;
        end else if (narrow) begin
          d.hwr_n = 1'h0;
        end else begin
          d.hwr_n = 1'h0;
          d.lwr_n = 1'h0;
        end
        d.wcnt = 2'h0;
        if (three && ctl_en && wmode == WAIT_PROGRAMMABLE) begin
          d.wcnt = q.wait_ctrl[WAIT_COUNT_LSB +: 2];
        end
      end
      ST_T2: begin
        if (three) begin
          if (q.wcnt != 2'h0) begin
            d.st = ST_TW;
          end else if (!wait_lvl && (!ctl_en || wmode == WAIT_PIN_1)) begin
            d.st = ST_TW;
          end else if (!wait_lvl && wmode == WAIT_PIN_AUTO) begin
            d.st = ST_TW;
          end else begin
            d.st = ST_T3;
          end
        end else begin
          d.st = ST_DONE;
        end
      end
      ST_TW: begin
        if (q.wcnt != 2'h0) begin
          d.wcnt = q.wcnt - 2'h1;
          if (q.wcnt == 2'h1 && !(wmode == WAIT_PIN_1 && !wait_lvl)) begin
            d.st = ST_T3;
          end
        end else if (wait_lvl || !(!ctl_en || wmode == WAIT_PIN_1 || wmode == WAIT_PIN_AUTO)) begin
          d.st = ST_T3;
        end
      end
      ST_T3: begin
        d.st = ST_DONE;
      end
      ST_DONE: begin
        if (!q.write) begin
          if (narrow) begin
            d.rbuf = q.second ? {q.rbuf[15:8], data_i[15:8]} : {data_i[15:8], data_i[15:8]};
          end else begin
            d.rbuf = data_i;
          end
        end
        d.rd_n = 1'h1;
        d.hwr_n = 1'h1;
        d.lwr_n = 1'h1;
        if (q.split && !q.second) begin
          d.second = 1'h1;
          d.addr = q.addr + ADDR_W'(1);
          d.wdata = {q.wdata[7:0], q.wdata[7:0]};
          d.st = ST_T1;
        end else begin
          d.st = ST_IDLE;
          d.rsp = 1'h1;
          d.cs_n = '1;
          d.as_n = 1'h1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.cs_ctrl <= CHIP_SELECT_CTRL_RST;
      q.width_ctrl <= AREA_WIDTH_NARROW_RST;
      q.state_ctrl <= AREA_STATE_COUNT_CTRL_RST;
      q.wait_ctrl <= WAIT_MODE_CTRL_RST;
      q.wait_en <= WAIT_INSERTION_ENABLE_RST;
      q.release_ctrl <= BUS_RELEASE_CTRL_RST;
      q.st <= ST_IDLE;
      q.cs_n <= '1;
      q.as_n <= 1'h1;
      q.rd_n <= 1'h1;
      q.hwr_n <= 1'h1;
      q.lwr_n <= 1'h1;
      q.boot <= 1'h1;
    end else if (clk_en_i) begin
      q <= d;
    end
  end
  assign reg_rdata_o = q.rdata;
  assign req_ready_o = (q.st == ST_IDLE) && (owner != OWN_EXTERNAL);
  assign rsp_valid_o = q.rsp;
  assign rsp_rdata_o = q.rbuf;
  assign owner_o = owner;
  assign addr_o = q.addr;
  assign data_o = q.wdata;
  assign chip_sel_n_o = q.cs_n;
  assign addr_valid_strobe_n_o = q.as_n;
  assign read_strobe_n_o = q.rd_n;
  assign upper_write_strobe_n_o = q.hwr_n;
  assign lower_write_strobe_n_o = q.lwr_n;
  assign addr_oe_n_o = (owner == OWN_EXTERNAL);
  assign strobe_oe_n_o = (owner == OWN_EXTERNAL);
  assign data_oe_n_o = (owner == OWN_EXTERNAL) || !q.write || q.st == ST_IDLE;
  assign bus_release_ack_n_o = (owner != OWN_EXTERNAL);
endmodule : external_bus_area_controller
`default_nettype wire

/* File: verification/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic clk_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic as_n_i,
  input wire logic rd_n_i,
  input wire logic hw_n_i,
  input wire logic lw_n_i,
  input wire logic stretch_i,
  input wire logic brq_i,
  output logic [15:0] rdata_o,
  output logic wait_n_o,
  output logic brq_n_o
);
  logic [7:0] mem [int];
  logic [15:0] noise_q = 16'h5A5A;
  logic as_q = 1'h1;
  int wcnt = 9;
  function automatic logic [7:0] rd8(int a);
    return mem.exists(a) ? mem[a] : 8'hC3;
  endfunction : rd8
  // released data lines toggle
  always_comb rdata_o = rd_n_i ? noise_q : {rd8(int'(addr_i)), rd8(int'(addr_i | 24'h1))};
  // wait held low ahead of the cycle so the filtered pin is seen in time
  assign wait_n_o = !(stretch_i && (as_n_i || wcnt < 6));
  assign brq_n_o = !brq_i;
  always @(posedge clk_i) begin
    noise_q <= ~noise_q;
    as_q <= as_n_i;
    if (as_q && !as_n_i) wcnt <= 0;
    else if (wcnt < 9) wcnt <= wcnt + 1;
    if (!hw_n_i) mem[int'(addr_i)] = wdata_i[15:8];
    if (!lw_n_i) mem[int'(addr_i | 24'h1)] = wdata_i[7:0];
  end
endmodule : ext_mem_model
`default_nettype wire

/* File: verification/bus_area_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_area_sva
  import bus_area_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire bus_area_pkg::owner_t owner_o,
  input wire logic addr_oe_n_o,
  input wire logic data_oe_n_o,
  input wire logic [7:0] chip_sel_n_o,
  input wire logic addr_valid_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic upper_write_strobe_n_o,
  input wire logic lower_write_strobe_n_o,
  input wire logic strobe_oe_n_o,
  input wire logic bus_release_ack_n_o
);
  import bus_area_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  release_float_a: assert property (!bus_release_ack_n_o |-> strobe_oe_n_o && addr_oe_n_o && data_oe_n_o)
    else $error("bus driven while released");
  ack_owner_a: assert property (!bus_release_ack_n_o |-> owner_o == OWN_EXTERNAL && !req_ready_o)
    else $error("ack without external owner");
  one_select_a: assert property ($onehot0(~chip_sel_n_o))
    else $error("two chip selects");
  rd_wr_excl_a: assert property (!read_strobe_n_o |-> upper_write_strobe_n_o && lower_write_strobe_n_o)
    else $error("read and write strobes together");
  upper_data_a: assert property (!upper_write_strobe_n_o |-> !data_oe_n_o)
    else $error("upper strobe without data");
  lower_data_a: assert property (!lower_write_strobe_n_o |-> !data_oe_n_o)
    else $error("lower strobe without data");
  addr_lead_a: assert property ($fell(addr_valid_strobe_n_o) |=> !read_strobe_n_o || !upper_write_strobe_n_o || !lower_write_strobe_n_o)
    else $error("no strobe after address");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 16'h1234 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  wait_ones_a: assert property (reg_rd_i && reg_addr_i == WAIT_MODE_CTRL_OFS |=> reg_rdata_o[7:4] == 4'hF)
    else $error("wait reserved bits not ones");
  rsp_bound_a: assert property (req_valid_i && req_ready_o |-> ##[2:60] rsp_valid_o)
    else $error("access never completed");
  cover property (!bus_release_ack_n_o);
  cover property ($fell(upper_write_strobe_n_o));
  cover property (rsp_valid_o);
endmodule : bus_area_sva
bind external_bus_area_controller bus_area_sva u_sva (.sys_clk_i, .reset_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .req_valid_i, .req_ready_o, .rsp_valid_o, .owner_o, .addr_oe_n_o, .data_oe_n_o,
  .chip_sel_n_o, .addr_valid_strobe_n_o, .read_strobe_n_o, .upper_write_strobe_n_o,
  .lower_write_strobe_n_o, .strobe_oe_n_o, .bus_release_ack_n_o);
`default_nettype wire

/* File: verification/external_bus_area_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_area_controller_tb_top;
  import bus_area_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, req_valid_i = 0, req_write_i = 0;
  logic dma_req_i = 0, refresh_req_i = 0, stretch = 0, brq = 0, rd_d = 0, acc_rd = 0;
  logic [15:0] reg_addr_i = 0, req_wdata_i = 0, data_i, rsp_rdata_o, data_o;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, chip_sel_n_o;
  logic [23:0] req_addr_i = 0, addr_o;
  logic req_ready_o, rsp_valid_o, addr_oe_n_o, data_oe_n_o, as_n, rd_n, hw_n, lw_n, soe_n;
  logic wait_n, brq_n, ack_n;
  owner_t owner_o;
  logic [15:0] exp_q[$];
  int err_total = 0, tests_run = 0, cyc = 0, lat = 0, base = 0;
  int seed = 32'hd9455127;
  logic [31:0] r;
  always #2.5 sys_clk_i = ~sys_clk_i;
  external_bus_area_controller u_dut (.sys_clk_i, .reset_i, .clk_en_i(1'h1), .op_mode_i(3'h2),
    .large_space_i(1'h1), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .req_valid_i, .req_write_i, .req_wide_i(1'h1), .req_addr_i, .req_wdata_i, .dma_req_i,
    .refresh_req_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .owner_o, .addr_o, .addr_oe_n_o,
    .data_o, .data_oe_n_o, .data_i, .chip_sel_n_o, .addr_valid_strobe_n_o(as_n),
    .read_strobe_n_o(rd_n), .upper_write_strobe_n_o(hw_n), .lower_write_strobe_n_o(lw_n),
    .strobe_oe_n_o(soe_n), .wait_req_n_i(wait_n), .bus_release_request_n_i(brq_n),
    .bus_release_ack_n_o(ack_n));
  ext_mem_model u_mem (.clk_i(sys_clk_i), .addr_i(addr_o), .wdata_i(data_o), .as_n_i(as_n),
    .rd_n_i(rd_n | soe_n), .hw_n_i(hw_n | soe_n), .lw_n_i(lw_n | soe_n), .stretch_i(stretch),
    .brq_i(brq), .rdata_o(data_i), .wait_n_o(wait_n), .brq_n_o(brq_n));
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic rg(logic w, logic [15:0] a, logic [7:0] d);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    if (!w) exp_q.push_back({8'h00, d});
    @(posedge sys_clk_i);
  endtask : rg
  task automatic rx;
    {reg_wr_i, reg_rd_i} <= 2'h0;
    @(posedge sys_clk_i);
  endtask : rx
  task automatic acc(logic w, logic [23:0] a, logic [15:0] d);
    req_valid_i <= 1'h1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    acc_rd <= !w;
    if (!w) exp_q.push_back(d);
    do @(posedge sys_clk_i); while (req_ready_o !== 1'h1);
    req_valid_i <= 1'h0;
    lat = 0;
    do begin
      @(posedge sys_clk_i);
      lat++;
    end while (rsp_valid_o !== 1'h1);
    @(posedge sys_clk_i);
  endtask : acc
  task automatic own(owner_t o);
    for (int i = 0; i < 20 && owner_o !== o; i++) @(posedge sys_clk_i);
    chk(16'(owner_o), 16'(o));
  endtask : own
  // result watcher
  always @(posedge sys_clk_i) begin
    rd_d <= reg_rd_i;
    cyc++;
    if (rd_d) chk({8'h00, reg_rdata_o}, exp_q.pop_front());
    if (rsp_valid_o === 1'h1 && acc_rd) chk(rsp_rdata_o, exp_q.pop_front());
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    rg(1'h0, AREA_WIDTH_CTRL_OFS, 8'h00);
    rg(1'h0, AREA_STATE_COUNT_CTRL_OFS, 8'hFF);
    rg(1'h0, WAIT_MODE_CTRL_OFS, 8'hF3);
    rg(1'h0, WAIT_INSERTION_ENABLE_OFS, 8'hFF);
    rg(1'h0, BUS_RELEASE_CTRL_OFS, 8'hFE);
    rg(1'h0, CHIP_SELECT_CTRL_OFS, 8'h0F);
    rg(1'h0, 16'h1234, 8'h00);
    rg(1'h0, MASTER_STATUS_OFS, 8'h00);
    r = $random(seed);
    rg(1'h1, WAIT_MODE_CTRL_OFS, r[7:0]);
    rg(1'h0, WAIT_MODE_CTRL_OFS, {4'hF, r[3:0]});
    rg(1'h1, AREA_STATE_COUNT_CTRL_OFS, 8'h00);
    rx();
    acc(1'h1, 24'h400000, r[15:0]);
    acc(1'h0, 24'h400000, r[15:0]);
    base = lat;
    stretch <= 1'h1;
    acc(1'h0, 24'h400000, r[15:0]);
    chk(16'(lat), 16'(base));
    stretch <= 1'h0;
    rg(1'h1, AREA_STATE_COUNT_CTRL_OFS, 8'h04);
    for (int wc = 0; wc < 4; wc++) begin
      rg(1'h1, WAIT_MODE_CTRL_OFS, 8'(wc));
      rx();
      acc(1'h0, 24'h400000, r[15:0]);
      chk(16'(lat), 16'(base + 1 + wc));
    end
    for (int m = 1; m < 4; m++) begin
      stretch <= (m != 1);
      rg(1'h1, WAIT_MODE_CTRL_OFS, 8'(m * 4));
      rx();
      acc(1'h0, 24'h400000, r[15:0]);
      chk(16'(lat > base + 1), 16'(m != 1));
    end
    rg(1'h1, WAIT_MODE_CTRL_OFS, 8'h04);
    rg(1'h1, WAIT_INSERTION_ENABLE_OFS, 8'hFB);
    rx();
    acc(1'h0, 24'h400000, r[15:0]);
    chk(16'(lat > base + 1), 16'h1);
    stretch <= 1'h0;
    rg(1'h1, AREA_WIDTH_CTRL_OFS, 8'h04);
    rx();
    acc(1'h1, 24'h400010, r[31:16]);
    acc(1'h0, 24'h400010, r[31:16]);
    rg(1'h1, AREA_WIDTH_CTRL_OFS, 8'h00);
    rx();
    acc(1'h0, 24'h400010, r[31:16]);
    dma_req_i <= 1'h1;
    own(OWN_DMA);
    refresh_req_i <= 1'h1;
    own(OWN_REFRESH);
    rg(1'h1, BUS_RELEASE_CTRL_OFS, 8'hFF);
    rx();
    brq <= 1'h1;
    own(OWN_EXTERNAL);
    chk(16'(ack_n), 16'h0);
    {brq, refresh_req_i, dma_req_i} <= 3'h0;
    own(OWN_CPU);
    give_verdict();
  end
endmodule : external_bus_area_controller_tb_top
`default_nettype wire
